/* qirq_outputs.sv */
// Interrupt pin drive and ready outputs of a four-channel UART
// How it works
// - Separate-strobe mode: pins A-D are channel interrupts
// - Separate-strobe mode: pin driven when enable bit set, else tristated
// - Single-select mode: pins B-D held low
// - Force input high overrides enable bit
// - No-pin variants: force tied high or low
// - Per-channel active-low transmit ready
// - Per-channel active-low receive ready
// - Combined transmit ready is AND of four
// - Combined receive ready is AND of four
// - Single-select: pin A is shared open-drain interrupt
// - Bus-style pin high selects separate strobes
`timescale 1ns/1ps
module qirq_outputs #(
    parameter bit HAS_FORCE_PIN = 1'b1,
    parameter bit FORCE_TIE_VALUE = 1'b0
) (
    input wire logic ref_clk, // 125 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic bus_style_pin, // Bus style strap pin
    input wire logic irq_continuous_force, // Interrupt select pin
    input wire logic [qirq_pkg::NUM_CHAN-1:0] irq_output_enable_bit, // Per-channel enable bit
    input wire qirq_pkg::qirq_chan_status_s chan_status, // Core status, same clock
    output qirq_pkg::qirq_irq_pins_s irq_pins, // Interrupt pins A-D level and enable
    output logic chan_a_tx_ready_n, // Channel A transmit ready
    output logic chan_b_tx_ready_n, // Channel B transmit ready
    output logic chan_c_tx_ready_n, // Channel C transmit ready
    output logic chan_d_tx_ready_n, // Channel D transmit ready
    output logic chan_a_rx_ready_n, // Channel A receive ready
    output logic chan_b_rx_ready_n, // Channel B receive ready
    output logic chan_c_rx_ready_n, // Channel C receive ready
    output logic chan_d_rx_ready_n, // Channel D receive ready
    output logic all_tx_ready_n, // Combined transmit ready
    output logic all_rx_ready_n, // Combined receive ready
    output qirq_pkg::qirq_mode_e bus_mode // Current bus mode
);
    import qirq_pkg::*;

    // Filtered pin levels; each pin passes four flops (three stages and the level flop) before it is used
    logic style_q;
    logic force_q;
    logic force_eff;
    logic strobe_mode;
    logic any_pending;
    logic [NUM_CHAN-1:0] lane_level;
    logic [NUM_CHAN-1:0] lane_oe;
    qirq_irq_pins_s next_irq_pins;
    qirq_mode_e next_bus_mode;
    logic [NUM_CHAN-1:0] tx_n;
    logic [NUM_CHAN-1:0] rx_n;
    logic [NUM_CHAN-1:0] next_tx_n;
    logic [NUM_CHAN-1:0] next_rx_n;
    logic next_all_tx_n;
    logic next_all_rx_n;

    // Strap is treated as single-select until the pin has been seen
    qirq_pin_sync #(
        .STAGES(SYNC_STAGES),
        .RESET_LEVEL(BUS_SINGLE_SELECT)
    ) style_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(bus_style_pin),
        .level(style_q)
    );

    // Reset level low keeps outputs gated by the enable bits until the pin is seen
    qirq_pin_sync #(
        .STAGES(SYNC_STAGES),
        .RESET_LEVEL(OE_RESET)
    ) force_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(irq_continuous_force),
        .level(force_q)
    );

    // Packages without the select pin behave as if it were strapped
    assign force_eff = HAS_FORCE_PIN ? force_q : FORCE_TIE_VALUE;

    assign strobe_mode = (style_q == BUS_SEPARATE_STROBE);
    assign any_pending = |chan_status.irq_pending;

    // One lane per pin; only pin A doubles as the shared device interrupt
    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_lane
        qirq_irq_lane #(
            .SHARED_PIN(ch == CHAN_A)
        ) lane (
            .strobe_mode(strobe_mode),
            .force_on(force_eff),
            .enable_bit(irq_output_enable_bit[ch]),
            .pending(chan_status.irq_pending[ch]),
            .any_pending(any_pending),
            .next_level(lane_level[ch]),
            .next_oe(lane_oe[ch])
        );
    end

    always_comb begin
        next_irq_pins.level = lane_level;
        next_irq_pins.oe = lane_oe;
    end

    always_comb begin
        next_bus_mode = QIRQ_MODE_SINGLE;
        if (strobe_mode) begin
            next_bus_mode = QIRQ_MODE_STROBE;
        end
    end

    always_comb begin
        next_tx_n = ~chan_status.tx_ready;
        next_rx_n = ~chan_status.rx_ready;
        next_all_tx_n = &next_tx_n;
        next_all_rx_n = &next_rx_n;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_pins <= '0;
            bus_mode <= QIRQ_MODE_RESET;
            tx_n <= '1;
            rx_n <= '1;
            all_tx_ready_n <= 1'b1;
            all_rx_ready_n <= 1'b1;
        end else begin
            irq_pins <= next_irq_pins;
            bus_mode <= next_bus_mode;
            tx_n <= next_tx_n;
            rx_n <= next_rx_n;
            all_tx_ready_n <= next_all_tx_n;
            all_rx_ready_n <= next_all_rx_n;
        end
    end

    assign chan_a_tx_ready_n = tx_n[0];
    assign chan_b_tx_ready_n = tx_n[1];
    assign chan_c_tx_ready_n = tx_n[2];
    assign chan_d_tx_ready_n = tx_n[3];
    assign chan_a_rx_ready_n = rx_n[0];
    assign chan_b_rx_ready_n = rx_n[1];
    assign chan_c_rx_ready_n = rx_n[2];
    assign chan_d_rx_ready_n = rx_n[3];
endmodule

// Pin synchroniser; a new level counts once the last two stages agree
module qirq_pin_sync #(
    parameter int STAGES = qirq_pkg::SYNC_STAGES,
    parameter bit RESET_LEVEL = 1'b0
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic pin, // Raw pin from outside the clock domain
    output logic level // Filtered level
);
    import qirq_pkg::*;

    logic [STAGES-1:0] stages;
    logic [STAGES-1:0] next_stages;
    logic next_level;

    always_comb begin
        next_stages = {stages[STAGES-2:0], pin};
        next_level = level;
        // A one-cycle glitch never sits in the last two stages at once
        if (stages[STAGES-1] == stages[STAGES-2]) begin
            next_level = stages[STAGES-1];
        end
    end

    // Costs two cycles more than a plain pair of flops, in return for glitch rejection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stages <= {STAGES{RESET_LEVEL}};
            level <= RESET_LEVEL;
        end else begin
            stages <= next_stages;
            level <= next_level;
        end
    end
endmodule

// Next drive of one interrupt pin from the bus mode, force level and channel state
module qirq_irq_lane #(
    parameter bit SHARED_PIN = 1'b0
) (
    input wire logic strobe_mode, // High in separate-strobe bus mode
    input wire logic force_on, // Effective interrupt select level
    input wire logic enable_bit, // This channel's output-enable bit
    input wire logic pending, // This channel has an enabled source pending
    input wire logic any_pending, // Some channel of the device has one pending
    output logic next_level, // Pin value while driven
    output logic next_oe // High while the pin is driven
);
    always_comb begin
        next_level = 1'b0;
        next_oe = 1'b0;
        if (strobe_mode) begin
            next_level = pending;
            next_oe = force_on | enable_bit;
        end else if (SHARED_PIN) begin
            // Open drain: pull low while any channel pends, release otherwise
            next_oe = any_pending;
        end else begin
            // Force input is ignored here; unused pins are driven low, never floated
            next_oe = 1'b1;
        end
    end
endmodule

/* qirq_pkg.sv */
// Package for the quad UART interrupt and ready output block
package qirq_pkg;
    localparam int NUM_CHAN = 4;
    localparam int CHAN_A = 0;
    localparam int SYNC_STAGES = 3;
    localparam logic BUS_SEPARATE_STROBE = 1'b1;
    localparam logic BUS_SINGLE_SELECT = 1'b0;
    localparam logic OE_RESET = 1'b0;

    // Per-channel status from the UART core
    typedef struct packed {
        logic [NUM_CHAN-1:0] irq_pending;
        logic [NUM_CHAN-1:0] tx_ready;
        logic [NUM_CHAN-1:0] rx_ready;
    } qirq_chan_status_s;

    // Interrupt pin drive, two signals per pin
    typedef struct packed {
        logic [NUM_CHAN-1:0] level;
        logic [NUM_CHAN-1:0] oe;
    } qirq_irq_pins_s;

    typedef enum logic [1:0] {
        QIRQ_MODE_RESET = 2'b00,
        QIRQ_MODE_STROBE = 2'b01,
        QIRQ_MODE_SINGLE = 2'b10
    } qirq_mode_e;
endpackage

/* qirq_outputs_monitor.sv */
// Assertions on the interrupt pin drive and ready outputs
`timescale 1ns/1ps
module qirq_outputs_monitor #(
    parameter bit HAS_FORCE_PIN = 1'b1,
    parameter bit FORCE_TIE_VALUE = 1'b0
) (
    input wire logic ref_clk, rst, bus_style_pin, irq_continuous_force, // Clock, reset, pins
    input wire logic [qirq_pkg::NUM_CHAN-1:0] irq_output_enable_bit, // Enable bits
    input wire qirq_pkg::qirq_chan_status_s chan_status, // Core status
    input wire qirq_pkg::qirq_irq_pins_s irq_pins, // Pin drive
    input wire logic chan_a_tx_ready_n, chan_b_tx_ready_n, chan_c_tx_ready_n, chan_d_tx_ready_n, // Tx
    input wire logic chan_a_rx_ready_n, chan_b_rx_ready_n, chan_c_rx_ready_n, chan_d_rx_ready_n, // Rx
    input wire logic all_tx_ready_n, all_rx_ready_n, // Combined
    input wire qirq_pkg::qirq_mode_e bus_mode // Mode
);
    import qirq_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [3:0] txn, rxn;
    logic stb, sgl, frc, frc_src;
    // Variants without the pin behave as if it were strapped
    assign frc_src = HAS_FORCE_PIN ? irq_continuous_force : FORCE_TIE_VALUE;
    assign txn = {chan_d_tx_ready_n, chan_c_tx_ready_n, chan_b_tx_ready_n, chan_a_tx_ready_n};
    assign rxn = {chan_d_rx_ready_n, chan_c_rx_ready_n, chan_b_rx_ready_n, chan_a_rx_ready_n};
    assign stb = bus_mode == QIRQ_MODE_STROBE;
    assign sgl = bus_mode == QIRQ_MODE_SINGLE;
    // Force is synchronised, so only judge once it has been steady long enough
    assign frc = stb && frc_src;
    chk_ready_map: assert property (!$past(rst) |->
        {txn, rxn} == ~$past({chan_status.tx_ready, chan_status.rx_ready})) else $error("ready map");
    chk_ready_and: assert property ({all_tx_ready_n, all_rx_ready_n} == {&txn, &rxn})
        else $error("combined ready");
    chk_strobe_level: assert property (stb && $past(stb) |->
        irq_pins.level == $past(chan_status.irq_pending)) else $error("strobe level");
    chk_strobe_enable: assert property (stb && !frc_src &&
        !$past(frc_src, 5) |-> irq_pins.oe == $past(irq_output_enable_bit))
        else $error("enable gating");
    chk_force_on: assert property (frc && $past(frc_src, 5) |-> irq_pins.oe == 4'hf)
        else $error("force override");
    chk_single_low: assert property (sgl |-> irq_pins.level == 4'h0 && irq_pins.oe[3:1] == 3'h7)
        else $error("single pins low");
    chk_shared_irq: assert property (sgl && $past(sgl) |->
        irq_pins.oe[0] == |$past(chan_status.irq_pending)) else $error("shared interrupt");
    chk_mode_select: assert property ($rose(bus_style_pin) |-> ##[3:5] stb)
        else $error("mode select");
    cover property (frc);
    cover property (sgl && irq_pins.oe[0]);
    cover property (!all_tx_ready_n && all_rx_ready_n);
endmodule

/* qirq_host_model.sv */
// Host board view of the interrupt pins
`timescale 1ns/1ps
module qirq_host_model (
    input wire logic ref_clk, // Clock
    input wire qirq_pkg::qirq_irq_pins_s irq_pins, // Pin drive
    output logic [qirq_pkg::NUM_CHAN-1:0] pin_level // Resolved wires
);
    import qirq_pkg::*;
    logic [NUM_CHAN-1:0] last = '0;
    always @(posedge ref_clk) last <= pin_level;
    // Pin A has a board pull-up; released B-D show the inverse of their last value
    always_comb pin_level = (irq_pins.oe & irq_pins.level) | (~irq_pins.oe & {~last[3:1], 1'b1});
endmodule

/* quad_uart_irq_ready_outputs_bench.sv */
// Testbench for the interrupt pin drive and ready outputs
`timescale 1ns/1ps
module quad_uart_irq_ready_outputs_bench;
    import qirq_pkg::*;
    logic ref_clk = 0, rst = 1, bus_style_pin = 0, irq_continuous_force = 0;
    logic [3:0] irq_output_enable_bit = 4'h0, pin_level;
    qirq_chan_status_s chan_status = '0;
    qirq_irq_pins_s irq_pins;
    logic chan_a_tx_ready_n, chan_b_tx_ready_n, chan_c_tx_ready_n, chan_d_tx_ready_n;
    logic chan_a_rx_ready_n, chan_b_rx_ready_n, chan_c_rx_ready_n, chan_d_rx_ready_n;
    logic all_tx_ready_n, all_rx_ready_n;
    qirq_mode_e bus_mode;
    qirq_irq_pins_s tied_irq_pins;
    int errors = 0, comparisons = 0;
    always #4 ref_clk = ~ref_clk;
    qirq_outputs dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus_style_pin(bus_style_pin),
        .irq_continuous_force(irq_continuous_force),
        .irq_output_enable_bit(irq_output_enable_bit),
        .chan_status(chan_status),
        .irq_pins(irq_pins),
        .chan_a_tx_ready_n(chan_a_tx_ready_n),
        .chan_b_tx_ready_n(chan_b_tx_ready_n),
        .chan_c_tx_ready_n(chan_c_tx_ready_n),
        .chan_d_tx_ready_n(chan_d_tx_ready_n),
        .chan_a_rx_ready_n(chan_a_rx_ready_n),
        .chan_b_rx_ready_n(chan_b_rx_ready_n),
        .chan_c_rx_ready_n(chan_c_rx_ready_n),
        .chan_d_rx_ready_n(chan_d_rx_ready_n),
        .all_tx_ready_n(all_tx_ready_n),
        .all_rx_ready_n(all_rx_ready_n),
        .bus_mode(bus_mode)
    );
    // Variant without the select pin, strapped to continuous interrupts
    qirq_outputs #(.HAS_FORCE_PIN(1'b0), .FORCE_TIE_VALUE(1'b1)) dut_tied (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus_style_pin(bus_style_pin),
        .irq_continuous_force(1'b0),
        .irq_output_enable_bit(irq_output_enable_bit),
        .chan_status(chan_status),
        .irq_pins(tied_irq_pins),
        .chan_a_tx_ready_n(),
        .chan_b_tx_ready_n(),
        .chan_c_tx_ready_n(),
        .chan_d_tx_ready_n(),
        .chan_a_rx_ready_n(),
        .chan_b_rx_ready_n(),
        .chan_c_rx_ready_n(),
        .chan_d_rx_ready_n(),
        .all_tx_ready_n(),
        .all_rx_ready_n(),
        .bus_mode()
    );
    qirq_host_model host (.ref_clk(ref_clk), .irq_pins(irq_pins), .pin_level(pin_level));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bounded wait for the synchronised mode to settle
    task automatic wait_mode(input qirq_mode_e m);
        for (int i = 0; i < 10 && bus_mode !== m; i++) step(1);
        check(8'(bus_mode), 8'(m));
        if (bus_mode !== m) final_report();
    endtask
    initial begin
        step(16);
        rst = 0;
        wait_mode(QIRQ_MODE_SINGLE);
        bus_style_pin = 1;
        wait_mode(QIRQ_MODE_STROBE);
        irq_output_enable_bit = 4'h5;
        chan_status.irq_pending = 4'ha;
        step(2);
        check({irq_pins.oe, irq_pins.level}, 8'h5a);
        check(tied_irq_pins.oe, 8'h0f);
        irq_continuous_force = 1;
        chan_status.tx_ready = 4'h2;
        step(6);
        check(irq_pins.oe, 8'h0f);
        check({chan_d_tx_ready_n, chan_c_tx_ready_n, chan_b_tx_ready_n, chan_a_tx_ready_n,
            chan_d_rx_ready_n, chan_c_rx_ready_n, chan_b_rx_ready_n, chan_a_rx_ready_n}, 8'hdf);
        check({all_tx_ready_n, all_rx_ready_n}, 8'h01);
        irq_continuous_force = 0;
        bus_style_pin = 0;
        wait_mode(QIRQ_MODE_SINGLE);
        step(1);
        check({irq_pins.oe, irq_pins.level}, 8'hf0);
        check(pin_level, 8'h00);
        chan_status.irq_pending = 4'h0;
        step(2);
        check({irq_pins.oe, pin_level[0]}, 8'h1d);
        final_report();
    end
endmodule
bind qirq_outputs qirq_outputs_monitor #(
    .HAS_FORCE_PIN(HAS_FORCE_PIN),
    .FORCE_TIE_VALUE(FORCE_TIE_VALUE)
) mon (.*);
